// >>> bmc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

module bmc_config_regs #(
    parameter longint unsigned STEP_CYCLES = bmc_pkg::STEP_CYCLES,
    parameter longint unsigned HALF_SLOW   = bmc_pkg::HALF_SLOW,
    parameter longint unsigned HALF_MID    = bmc_pkg::HALF_MID,
    parameter longint unsigned HALF_FAST   = bmc_pkg::HALF_FAST
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire bmc_pkg::bmc_wr_cmd_t wr_cmd,
    input  wire bmc_pkg::bmc_conv_t   conv,
    input  wire logic                 hw_power_down,
    input  wire logic                 alert_in,
    output logic                      alert_out,
    output bmc_pkg::bmc_fwd_t         fwd,
    output logic [4:0]                crc_dev_addr,
    output logic [7:0]                rd_data,
    output logic                      chain_read_en,
    output logic [1:0]                avg_mode,
    output logic [1:0]                acq_time,
    output logic                      thermistor_termination_pin,
    output logic                      sleep_request,
    output logic                      soft_reset_hold,
    output logic [6:1]                balance_output_n
);

    // ------
    // register state
    // ------
    logic [7:0] ctrl_hi_reg,   ctrl_hi_next;
    logic [7:0] ctrl_lo_reg,   ctrl_lo_next;
    logic [7:0] cell_hi_reg,   cell_hi_next;
    logic [7:0] cell_lo_reg,   cell_lo_next;
    logic [7:0] aux_hi_reg,    aux_hi_next;
    logic [7:0] aux_lo_reg,    aux_lo_next;
    logic [7:0] alert_cfg_reg, alert_cfg_next;
    logic [7:0] balance_reg,   balance_next;
    logic [7:0] sleep_tmr_reg, sleep_tmr_next;
    logic [7:0] read_sel_reg,  read_sel_next;
    logic [4:0] lock_addr_reg, lock_addr_next;
    logic [7:0] btimer_reg     [bmc_pkg::NUM_BAL];
    logic [7:0] btimer_next    [bmc_pkg::NUM_BAL];

    logic       wr_hit;
    logic       sw_rst;
    logic [5:0] bal_expire;
    logic       sleep_expired;
    logic [5:0] bidx;

    assign sw_rst = ctrl_lo_reg[bmc_pkg::LO_SW_RST];
    assign wr_hit = wr_cmd.valid && (wr_cmd.all || wr_cmd.dev_addr == crc_dev_addr);
    assign bidx   = wr_cmd.reg_addr - bmc_pkg::ADDR_BTIMER0;

    // ------
    // register write and software reset
    // ------
    always_comb begin
        ctrl_hi_next   = ctrl_hi_reg;
        ctrl_lo_next   = ctrl_lo_reg;
        cell_hi_next   = cell_hi_reg;
        cell_lo_next   = cell_lo_reg;
        aux_hi_next    = aux_hi_reg;
        aux_lo_next    = aux_lo_reg;
        alert_cfg_next = alert_cfg_reg;
        balance_next   = balance_reg;
        sleep_tmr_next = sleep_tmr_reg;
        read_sel_next  = read_sel_reg;
        lock_addr_next = lock_addr_reg;
        for (int i = 0; i < bmc_pkg::NUM_BAL; i++) begin
            btimer_next[i] = btimer_reg[i];
        end
        // lower control byte survives a software reset
        if (wr_hit && wr_cmd.reg_addr == bmc_pkg::ADDR_CTRL_LO) begin
            ctrl_lo_next = wr_cmd.data;
            if (wr_cmd.data[bmc_pkg::LO_LOCK]) begin
                lock_addr_next = wr_cmd.dev_addr;
            end
        end
        if (sw_rst) begin
            // held at defaults for as long as reset bit stays high
            ctrl_hi_next   = bmc_pkg::RST_CTRL_HI;
            cell_hi_next   = bmc_pkg::RST_HIGH_THR;
            cell_lo_next   = bmc_pkg::RST_LOW_THR;
            aux_hi_next    = bmc_pkg::RST_HIGH_THR;
            aux_lo_next    = bmc_pkg::RST_LOW_THR;
            alert_cfg_next = bmc_pkg::RST_ZERO;
            balance_next   = bmc_pkg::RST_ZERO;
            sleep_tmr_next = bmc_pkg::RST_ZERO;
            read_sel_next  = bmc_pkg::RST_ZERO;
            for (int i = 0; i < bmc_pkg::NUM_BAL; i++) begin
                btimer_next[i] = bmc_pkg::RST_ZERO;
            end
        end else if (wr_hit) begin
            unique case (wr_cmd.reg_addr)
                bmc_pkg::ADDR_CTRL_HI:   ctrl_hi_next   = wr_cmd.data;
                bmc_pkg::ADDR_CELL_HI:   cell_hi_next   = wr_cmd.data;
                bmc_pkg::ADDR_CELL_LO:   cell_lo_next   = wr_cmd.data;
                bmc_pkg::ADDR_AUX_HI:    aux_hi_next    = wr_cmd.data;
                bmc_pkg::ADDR_AUX_LO:    aux_lo_next    = wr_cmd.data;
                bmc_pkg::ADDR_ALERT:     alert_cfg_next = wr_cmd.data;
                bmc_pkg::ADDR_BALANCE:   balance_next = wr_cmd.data & bmc_pkg::BALANCE_MASK;
                bmc_pkg::ADDR_SLEEP_TMR: sleep_tmr_next = wr_cmd.data & bmc_pkg::TIMER_MASK;
                bmc_pkg::ADDR_READ_SEL:  read_sel_next  = wr_cmd.data & bmc_pkg::BALANCE_MASK;
                default: begin
                    if (wr_cmd.reg_addr >= bmc_pkg::ADDR_BTIMER0 &&
                        wr_cmd.reg_addr <  bmc_pkg::ADDR_SLEEP_TMR) begin
                        btimer_next[bidx[2:0]] = wr_cmd.data & bmc_pkg::TIMER_MASK;
                    end
                end
            endcase
        end
        // expiry clears after the write so a running timer always wins its bit
        balance_next = balance_next & ~{bal_expire, 2'b00};
        if (hw_power_down || sleep_expired) begin
            balance_next = bmc_pkg::RST_ZERO;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_hi_reg   <= bmc_pkg::RST_CTRL_HI;
            ctrl_lo_reg   <= bmc_pkg::RST_CTRL_LO;
            cell_hi_reg   <= bmc_pkg::RST_HIGH_THR;
            cell_lo_reg   <= bmc_pkg::RST_LOW_THR;
            aux_hi_reg    <= bmc_pkg::RST_HIGH_THR;
            aux_lo_reg    <= bmc_pkg::RST_LOW_THR;
            alert_cfg_reg <= bmc_pkg::RST_ZERO;
            balance_reg   <= bmc_pkg::RST_ZERO;
            sleep_tmr_reg <= bmc_pkg::RST_ZERO;
            read_sel_reg  <= bmc_pkg::RST_ZERO;
            lock_addr_reg <= 5'h00;
            for (int i = 0; i < bmc_pkg::NUM_BAL; i++) begin
                btimer_reg[i] <= bmc_pkg::RST_ZERO;
            end
        end else begin
            ctrl_hi_reg   <= ctrl_hi_next;
            ctrl_lo_reg   <= ctrl_lo_next;
            cell_hi_reg   <= cell_hi_next;
            cell_lo_reg   <= cell_lo_next;
            aux_hi_reg    <= aux_hi_next;
            aux_lo_reg    <= aux_lo_next;
            alert_cfg_reg <= alert_cfg_next;
            balance_reg   <= balance_next;
            sleep_tmr_reg <= sleep_tmr_next;
            read_sel_reg  <= read_sel_next;
            lock_addr_reg <= lock_addr_next;
            for (int i = 0; i < bmc_pkg::NUM_BAL; i++) begin
                btimer_reg[i] <= btimer_next[i];
            end
        end
    end

    // ------
    // control outputs and chain addressing
    // ------
    assign avg_mode        = ctrl_hi_reg[bmc_pkg::HI_AVG_LSB +: 2];
    assign acq_time        = ctrl_lo_reg[bmc_pkg::LO_ACQ_LSB +: 2];
    // host is trusted to pair this with the longest acquisition time
    assign thermistor_termination_pin = ctrl_lo_reg[bmc_pkg::LO_THERM];
    assign chain_read_en   = ctrl_lo_reg[bmc_pkg::LO_READBACK];
    assign soft_reset_hold = sw_rst;
    assign sleep_request   = ctrl_hi_reg[bmc_pkg::HI_SW_PD] || sleep_expired;
    assign crc_dev_addr    = ctrl_lo_reg[bmc_pkg::LO_LOCK] ? lock_addr_reg : 5'h00;

    bmc_pkg::bmc_fwd_t fwd_reg, fwd_next;

    always_comb begin
        fwd_next.valid    = wr_cmd.valid;
        fwd_next.dev_addr = ctrl_lo_reg[bmc_pkg::LO_INC] ? wr_cmd.dev_addr + 5'h01
                                                         : wr_cmd.dev_addr;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwd_reg <= '0;
        end else begin
            fwd_reg <= fwd_next;
        end
    end

    assign fwd = fwd_reg;

    // ------
    // readback mux
    // ------
    logic [7:0] rd_data_reg, rd_data_next;
    logic [5:0] rd_addr;
    logic [5:0] rd_bidx;

    assign rd_addr = read_sel_reg[bmc_pkg::BAL_LSB +: 6];
    assign rd_bidx = rd_addr - bmc_pkg::ADDR_BTIMER0;

    always_comb begin
        unique case (rd_addr)
            bmc_pkg::ADDR_CTRL_HI:   rd_data_next = ctrl_hi_reg;
            bmc_pkg::ADDR_CTRL_LO:   rd_data_next = ctrl_lo_reg;
            bmc_pkg::ADDR_CELL_HI:   rd_data_next = cell_hi_reg;
            bmc_pkg::ADDR_CELL_LO:   rd_data_next = cell_lo_reg;
            bmc_pkg::ADDR_AUX_HI:    rd_data_next = aux_hi_reg;
            bmc_pkg::ADDR_AUX_LO:    rd_data_next = aux_lo_reg;
            bmc_pkg::ADDR_ALERT:     rd_data_next = alert_cfg_reg;
            bmc_pkg::ADDR_BALANCE:   rd_data_next = balance_reg;
            bmc_pkg::ADDR_SLEEP_TMR: rd_data_next = sleep_tmr_reg;
            bmc_pkg::ADDR_READ_SEL:  rd_data_next = read_sel_reg;
            default: begin
                if (rd_addr >= bmc_pkg::ADDR_BTIMER0 && rd_addr < bmc_pkg::ADDR_SLEEP_TMR) begin
                    rd_data_next = btimer_reg[rd_bidx[2:0]];
                end else begin
                    rd_data_next = 8'h00;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

    // ------
    // common step tick
    // ------
    logic [35:0] tick_cnt_reg, tick_cnt_next;
    logic        tick;

    assign tick = (tick_cnt_reg == 36'(STEP_CYCLES - 1));

    always_comb begin
        tick_cnt_next = tick ? 36'h0 : tick_cnt_reg + 36'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 36'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // ------
    // balance timers
    // ------
    genvar g;
    generate
        for (g = 0; g < bmc_pkg::NUM_BAL; g++) begin : g_bal
            logic [4:0] steps_reg, steps_next;
            logic [4:0] code;
            logic       active;

            assign code   = btimer_reg[g][bmc_pkg::TMR_CODE_LSB +: 5];
            assign active = (code != 5'h00) && balance_reg[bmc_pkg::BAL_LSB + g];
            assign bal_expire[g] = active && tick && (steps_reg + 5'h01 == code);

            always_comb begin
                if (!active) begin
                    steps_next = 5'h00;
                end else if (tick) begin
                    steps_next = steps_reg + 5'h01;
                end else begin
                    steps_next = steps_reg;
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    steps_reg <= 5'h00;
                end else begin
                    steps_reg <= steps_next;
                end
            end
        end
    endgenerate

    // bits 1..0 are never set, so outputs map straight from 7..2
    assign balance_output_n = balance_reg[7:2];

    // ------
    // automatic power-down timer
    // ------
    logic [4:0] sleep_steps_reg, sleep_steps_next;
    logic       sleep_exp_reg,   sleep_exp_next;
    logic [4:0] sleep_code;

    assign sleep_code    = sleep_tmr_reg[bmc_pkg::TMR_CODE_LSB +: 5];
    assign sleep_expired = sleep_exp_reg;

    always_comb begin
        sleep_steps_next = sleep_steps_reg;
        sleep_exp_next   = sleep_exp_reg;
        if (sw_rst || sleep_code == 5'h00 ||
            (wr_hit && wr_cmd.reg_addr == bmc_pkg::ADDR_SLEEP_TMR)) begin
            // rewriting the code restarts the countdown
            sleep_steps_next = 5'h00;
            sleep_exp_next   = 1'b0;
        end else if (tick && !sleep_exp_reg) begin
            sleep_steps_next = sleep_steps_reg + 5'h01;
            if (sleep_steps_reg + 5'h01 == sleep_code) begin
                sleep_exp_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_steps_reg <= 5'h00;
            sleep_exp_reg   <= 1'b0;
        end else begin
            sleep_steps_reg <= sleep_steps_next;
            sleep_exp_reg   <= sleep_exp_next;
        end
    end

    // ------
    // limit detection and alert output
    // ------
    logic        violation_reg, violation_next;
    logic        viol_now;
    logic [7:0]  conv_top;
    logic [31:0] sq_cnt_reg, sq_cnt_next;
    logic        sq_reg,     sq_next;
    logic [31:0] sq_half;
    logic        alert_reg,  alert_next;
    logic [1:0]  alert_mode;
    logic [1:0]  alert_freq;

    assign conv_top   = conv.code[bmc_pkg::CONV_CMP_LSB +: 8];
    assign alert_mode = alert_cfg_reg[bmc_pkg::ALERT_MODE_LSB +: 2];
    assign alert_freq = alert_cfg_reg[bmc_pkg::ALERT_FREQ_LSB +: 2];

    always_comb begin
        viol_now = 1'b0;
        if (conv.valid) begin
            if (conv.is_aux) begin
                viol_now = (conv_top > aux_hi_reg) || (conv_top < aux_lo_reg);
            end else begin
                viol_now = (conv_top > cell_hi_reg) || (conv_top < cell_lo_reg);
            end
        end
        // a new violation outranks the software reset clear
        violation_next = viol_now ? 1'b1 : (sw_rst ? 1'b0 : violation_reg);
    end

    always_comb begin
        if (alert_freq == bmc_pkg::FREQ_100HZ) begin
            sq_half = 32'(HALF_SLOW);
        end else if (alert_freq == bmc_pkg::FREQ_1KHZ) begin
            sq_half = 32'(HALF_MID);
        end else begin
            sq_half = 32'(HALF_FAST);
        end
        if (sq_cnt_reg >= sq_half - 32'h1) begin
            sq_cnt_next = 32'h0;
            sq_next     = ~sq_reg;
        end else begin
            sq_cnt_next = sq_cnt_reg + 32'h1;
            sq_next     = sq_reg;
        end
        unique case (alert_mode)
            bmc_pkg::MODE_DYNAMIC: alert_next = sq_reg && !violation_reg;
            bmc_pkg::MODE_PASS:    alert_next = alert_in && !violation_reg;
            default:               alert_next = !violation_reg;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            violation_reg <= 1'b0;
            sq_cnt_reg    <= 32'h0;
            sq_reg        <= 1'b1;
            alert_reg     <= 1'b1;
        end else begin
            violation_reg <= violation_next;
            sq_cnt_reg    <= sq_cnt_next;
            sq_reg        <= sq_next;
            alert_reg     <= alert_next;
        end
    end

    assign alert_out = alert_reg;

endmodule // bmc_config_regs

`default_nettype wire

// >>> bmc_config_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_chk (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire bmc_pkg::bmc_wr_cmd_t wr_cmd,
    input wire bmc_pkg::bmc_conv_t   conv,
    input wire logic                 hw_power_down,
    input wire logic                 alert_out,
    input wire bmc_pkg::bmc_fwd_t    fwd,
    input wire logic [4:0]           crc_dev_addr,
    input wire logic [7:0]           rd_data,
    input wire logic                 chain_read_en,
    input wire logic [1:0]           avg_mode,
    input wire logic [1:0]           acq_time,
    input wire logic                 sleep_request,
    input wire logic                 soft_reset_hold,
    input wire logic [6:1]           balance_output_n
);
    // ------
    // port relations
    // ------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire hit = wr_cmd.valid && (wr_cmd.all || wr_cmd.dev_addr == crc_dev_addr);
    wire [5:0] ra = wr_cmd.reg_addr;
    property p_fwd; wr_cmd.valid |=> fwd.valid; endproperty
    a_fwd: assert property (p_fwd) else $error("forward missing");
    property p_bal; hit && ra == bmc_pkg::ADDR_BALANCE && !soft_reset_hold && !hw_power_down
        && !sleep_request |=> balance_output_n == $past(wr_cmd.data[7:2]); endproperty
    a_bal: assert property (p_bal) else $error("balance write");
    property p_clr; soft_reset_hold || hw_power_down |=> balance_output_n == 6'h00; endproperty
    a_clr: assert property (p_clr) else $error("balance not cleared");
    // static default and flag clear need two edges to reach the pin
    property p_alr; (soft_reset_hold && !conv.valid) [*2] |=> alert_out; endproperty
    a_alr: assert property (p_alr) else $error("alert stuck");
    property p_lo; hit && ra == bmc_pkg::ADDR_CTRL_LO |=> {soft_reset_hold, acq_time,
        chain_read_en} == {$past(wr_cmd.data[7:5]), $past(wr_cmd.data[0])}; endproperty
    a_lo: assert property (p_lo) else $error("control low");
    property p_hi; hit && ra == bmc_pkg::ADDR_CTRL_HI && !soft_reset_hold |=> avg_mode ==
        $past(wr_cmd.data[2:1]) && (sleep_request || !$past(wr_cmd.data[0])); endproperty
    a_hi: assert property (p_hi) else $error("control high");
    property p_lck; hit && ra == bmc_pkg::ADDR_CTRL_LO && wr_cmd.data[2] |=>
        crc_dev_addr == $past(wr_cmd.dev_addr); endproperty
    a_lck: assert property (p_lck) else $error("address lock");
    property p_rd; hit && ra == bmc_pkg::ADDR_READ_SEL && !soft_reset_hold && wr_cmd.data[7:2]
        == bmc_pkg::ADDR_BALANCE ##1 !wr_cmd.valid |=> rd_data == {$past(balance_output_n),
        2'b00}; endproperty
    a_rd: assert property (p_rd) else $error("readback");
    c_bal: cover property (hit && ra == bmc_pkg::ADDR_BALANCE);
    c_alr: cover property ($fell(alert_out));
    c_slp: cover property ($rose(sleep_request));
endmodule // bmc_chk
bind bmc_config_regs bmc_chk bmc_chk_inst (.clk(clk), .rst(rst), .wr_cmd(wr_cmd),
    .conv(conv), .hw_power_down(hw_power_down), .alert_out(alert_out), .fwd(fwd),
    .crc_dev_addr(crc_dev_addr), .rd_data(rd_data), .chain_read_en(chain_read_en),
    .avg_mode(avg_mode), .acq_time(acq_time), .sleep_request(sleep_request),
    .soft_reset_hold(soft_reset_hold), .balance_output_n(balance_output_n));
`default_nettype wire

// >>> bmc_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module bmc_config_regs_tb_top;
    typedef struct {string nm; int k; logic [7:0] e;} bmc_note_t;
    logic clk = 1'b0, rst = 1'b1, hw_power_down = 1'b0, alert_in = 1'b1;
    bmc_pkg::bmc_wr_cmd_t wr_cmd;
    bmc_pkg::bmc_conv_t conv;
    bmc_pkg::bmc_fwd_t fwd;
    logic alert_out, chain_read_en, therm, sleep_request, soft_reset_hold;
    logic [4:0] crc_dev_addr;
    logic [7:0] rd_data;
    logic [1:0] avg_mode, acq_time;
    logic [6:1] balance_output_n;
    int num_errors = 0, comparisons = 0, seed = 94920;
    bmc_note_t q[$];
    event res_ev;
    always #4 clk = ~clk;
    bmc_host bmc_host_inst (.clk(clk), .wr_cmd(wr_cmd), .conv(conv));
    bmc_config_regs #(.STEP_CYCLES(20), .HALF_SLOW(16), .HALF_MID(8), .HALF_FAST(4))
        bmc_config_regs_inst (.clk(clk), .rst(rst), .wr_cmd(wr_cmd), .conv(conv),
        .hw_power_down(hw_power_down), .alert_in(alert_in), .alert_out(alert_out), .fwd(fwd),
        .crc_dev_addr(crc_dev_addr), .rd_data(rd_data), .chain_read_en(chain_read_en),
        .avg_mode(avg_mode), .acq_time(acq_time), .thermistor_termination_pin(therm),
        .sleep_request(sleep_request), .soft_reset_hold(soft_reset_hold),
        .balance_output_n(balance_output_n));
    // ------
    // notes, monitor and verdict
    // ------
    function automatic logic [7:0] act(int k);
        return k == 0 ? rd_data : k == 1 ? {balance_output_n, 2'b00} :
            k == 2 ? {sleep_request, alert_out, 6'h00} : {therm, 2'h0, fwd.dev_addr};
    endfunction
    task automatic see(string n, int k, logic [7:0] e);
        q.push_back('{n, k, e});
        ->res_ev;
    endtask
    task automatic rd(string n, logic [5:0] a, logic [7:0] e);
        bmc_host_inst.write(bmc_pkg::ADDR_READ_SEL, {a, 2'b00});
        repeat (2) @(negedge clk);
        see(n, 0, e);
    endtask
    task automatic wait_see(string n, int k, logic [7:0] e, int lim);
        int i;
        for (i = 0; i < lim && act(k) !== e; i++) @(negedge clk);
        if (i == lim) begin num_errors++; print_verdict(); end
        see(n, k, e);
    endtask
    task automatic swrst();
        bmc_host_inst.write(6'h0e, 8'h93);
        bmc_host_inst.write(6'h0e, 8'h13);
        repeat (3) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(res_ev) while (q.size() > 0) begin
        bmc_note_t n;
        n = q.pop_front();
        `CHK(n.nm, n.e, act(n.k))
    end
    initial begin
        logic [7:0] d;
        logic [5:0] ra[11] = '{6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12,
            6'h13, 6'h14, 6'h15, 6'h1b, 6'h3f};
        logic [7:0] rv[11] = '{8'h00, 8'h13, 8'hff, 8'h00, 8'hff, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [5:0] tr[4] = '{6'h0f, 6'h10, 6'h12, 6'h0f};
        logic [7:0] tv[4] = '{8'h80, 8'h40, 8'h40, 8'h80};
        logic [11:0] cc[4] = '{12'h900, 12'h100, 12'h100, 12'h80f};
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int i = 0; i < 11; i++) rd("reset value", ra[i], rv[i]);
        for (int i = 2; i < 8; i++) begin
            d = 8'($random(seed));
            bmc_host_inst.write(ra[i], d);
            rd("write read", ra[i], i == 7 ? d & 8'hfc : d);
        end
        $display("done: registers");
        bmc_host_inst.write(6'h0e, 8'h93);
        bmc_host_inst.write(6'h0f, 8'h12);
        bmc_host_inst.write(6'h0e, 8'h13);
        rd("soft reset keeps", 6'h0f, 8'hff);
        rd("soft reset balance", 6'h14, 8'h00);
        rd("soft reset low byte", 6'h0e, 8'h13);
        for (int j = 0; j < 4; j++) begin
            bmc_host_inst.write(tr[j], tv[j]);
            bmc_host_inst.send(j == 2, cc[j]);
            repeat (3) @(negedge clk);
            see("alert", 2, j == 3 ? 8'h40 : 8'h00);
            swrst();
            see("alert cleared", 2, 8'h40);
        end
        bmc_host_inst.write(6'h13, 8'h80);
        @(negedge clk) alert_in = 1'b0;
        wait_see("pass-through", 2, 8'h00, 3);
        bmc_host_inst.write(6'h13, 8'h60);
        wait_see("dynamic high", 2, 8'h40, 9);
        wait_see("dynamic low", 2, 8'h00, 9);
        swrst();
        $display("done: alert");
        bmc_host_inst.write(6'h14, 8'hfc);
        see("balance on", 1, 8'hfc);
        bmc_host_inst.write(6'h15, 8'h10);
        wait_see("balance timer", 1, 8'hf8, 60);
        bmc_host_inst.write(6'h1b, 8'h18);
        wait_see("sleep timer", 2, 8'hc0, 80);
        wait_see("sleep clears balance", 1, 8'h00, 2);
        swrst();
        $display("done: timers");
        bmc_host_inst.write(6'h14, 8'h84);
        see("balance set", 1, 8'h84);
        @(negedge clk) hw_power_down = 1'b1;
        @(negedge clk) hw_power_down = 1'b0;
        see("power-down clears", 1, 8'h00);
        for (int j = 0; j < 4; j++) begin
            bmc_host_inst.write(6'h0e, {1'b0, 2'(j), 3'h7, j[1:0]}, 5'(j + 3));
            bmc_host_inst.write(6'h0d, {5'h00, 2'(j), 1'b0}, 5'(j));
            see("termination and forward", 3, {j == 3, 2'h0, 5'(j + j[1])});
        end
        bmc_host_inst.write(6'h0e, 8'h13);
        bmc_host_inst.write(6'h0d, 8'h01);
        @(negedge clk);
        see("soft power-down", 2, 8'hc0);
        @(negedge clk);
        $display("done: control");
        print_verdict();
    end
endmodule // bmc_config_regs_tb_top
`default_nettype wire

// >>> bmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_host (
    input  wire logic            clk,
    output bmc_pkg::bmc_wr_cmd_t wr_cmd,
    output bmc_pkg::bmc_conv_t   conv
);
    // ------
    // host commands, released fields inverted
    // ------
    initial wr_cmd = '0;
    initial conv = '0;
    task automatic write(logic [5:0] ra, logic [7:0] d, logic [4:0] da = 5'h00);
        if (ra == bmc_pkg::ADDR_CTRL_LO && d[6:5] != 2'b11) d[3] = 1'b0;
        if (ra == bmc_pkg::ADDR_READ_SEL) d[1:0] = 2'b00;
        @(negedge clk) wr_cmd <= '{1'b1, da, ra, d, 1'b1};
        @(negedge clk) wr_cmd <= '{1'b0, ~da, ~ra, ~d, 1'b0};
    endtask
    task automatic send(logic aux, logic [11:0] c);
        @(negedge clk) conv <= '{1'b1, aux, c};
        @(negedge clk) conv <= '{1'b0, ~aux, ~c};
    endtask
endmodule // bmc_host
`default_nettype wire

// >>> bmc_pkg.sv
// Operation
// - averaging field picks 1, 2, 4 or 8 conversions; reset 00.
// - control D8 selects software power-down; reset 0.
// - software reset: write D7 high to hold, then low to release.
// - software reset restores defaults in all registers but the lower control byte.
// - acquisition time field, reset 00 (400 ns).
// - lock bit D2 adopts the presented address for CRC, else 0x00.
// - increment bit D1 adds one to the forwarded address; reset 1.
// - readback bit D0 enables chained readback of the selected register; reset 1.
// - cell result above the high threshold raises alert; reset 0xff.
// - cell result below the low threshold raises alert; reset 0x00.
// - aux result outside aux thresholds raises alert; resets 0xff, 0x00.
// - static alert idles high, low once any violation occurred.
// - dynamic alert is a 100 Hz, 1 kHz or 10 kHz square wave.
// - top device picks alert mode; others pass it through or pull low.
// - balance bits 7..2 drive outputs six..one; bits 1..0 reserved zero.
// - balance clears on power-up, software reset and hardware power-down.
// - balance timer: 5-bit code in bits 7..3, 71.5 s steps.
// - timer code zero disables the timer; timers reset 0x00.
// - power-down timer code in bits 7..3 powers down on expiry.
package bmc_pkg;

    // ------
    // register addresses
    // ------
    localparam logic [5:0] ADDR_CTRL_HI   = 6'h0d;
    localparam logic [5:0] ADDR_CTRL_LO   = 6'h0e;
    localparam logic [5:0] ADDR_CELL_HI   = 6'h0f;
    localparam logic [5:0] ADDR_CELL_LO   = 6'h10;
    localparam logic [5:0] ADDR_AUX_HI    = 6'h11;
    localparam logic [5:0] ADDR_AUX_LO    = 6'h12;
    localparam logic [5:0] ADDR_ALERT     = 6'h13;
    localparam logic [5:0] ADDR_BALANCE   = 6'h14;
    localparam logic [5:0] ADDR_BTIMER0   = 6'h15;
    localparam logic [5:0] ADDR_SLEEP_TMR = 6'h1b;
    localparam logic [5:0] ADDR_READ_SEL  = 6'h1c;
    localparam int         NUM_BAL        = 6;

    // ------
    // reset values
    // ------
    localparam logic [7:0] RST_CTRL_HI    = 8'h00;
    localparam logic [7:0] RST_CTRL_LO    = 8'h13;
    localparam logic [7:0] RST_HIGH_THR   = 8'hff;
    localparam logic [7:0] RST_LOW_THR    = 8'h00;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] BALANCE_MASK   = 8'hfc;
    localparam logic [7:0] TIMER_MASK     = 8'hf8;

    // ------
    // field positions (control high byte holds D15..D8)
    // ------
    localparam int HI_AVG_LSB   = 1;
    localparam int HI_SW_PD     = 0;
    localparam int LO_SW_RST    = 7;
    localparam int LO_ACQ_LSB   = 5;
    localparam int LO_THERM     = 3;
    localparam int LO_LOCK      = 2;
    localparam int LO_INC       = 1;
    localparam int LO_READBACK  = 0;
    localparam int TMR_CODE_LSB = 3;
    localparam int BAL_LSB      = 2;
    localparam int ALERT_MODE_LSB = 6;
    localparam int ALERT_FREQ_LSB = 4;
    localparam int CONV_CMP_LSB   = 4;

    // ------
    // alert modes and frequencies
    // ------
    localparam logic [1:0] MODE_STATIC  = 2'h0;
    localparam logic [1:0] MODE_DYNAMIC = 2'h1;
    localparam logic [1:0] MODE_PASS    = 2'h2;
    localparam logic [1:0] FREQ_100HZ   = 2'h0;
    localparam logic [1:0] FREQ_1KHZ    = 2'h1;

    // ------
    // timing
    // ------
    localparam longint unsigned CLK_HZ      = 125000000;
    localparam real             STEP_SEC    = 71.5;
    localparam longint unsigned STEP_CYCLES = longint'(STEP_SEC * real'(CLK_HZ));
    localparam longint unsigned HZ_SLOW     = 100;
    localparam longint unsigned HZ_MID      = 1000;
    localparam longint unsigned HZ_FAST     = 10000;
    localparam longint unsigned HALF_SLOW   = CLK_HZ / (2 * HZ_SLOW);
    localparam longint unsigned HALF_MID    = CLK_HZ / (2 * HZ_MID);
    localparam longint unsigned HALF_FAST   = CLK_HZ / (2 * HZ_FAST);

    // ------
    // carriers
    // ------
    typedef struct packed {
        logic       valid;
        logic [4:0] dev_addr;
        logic [5:0] reg_addr;
        logic [7:0] data;
        logic       all;
    } bmc_wr_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        is_aux;
        logic [11:0] code;
    } bmc_conv_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] dev_addr;
    } bmc_fwd_t;

endpackage
